// ### hw/puc_coordinator.v
// Parallel group coordinator: discovery, totals, distribution, alarms.
`timescale 1ns/1ps
`include "puc_map.vh"
module puc_coordinator #(
   parameter VW      = 24,
   parameter TMO_CYC = `PUC_REPLY_TMO_CYC,
   parameter BIT_CYC = `PUC_BIT_CYC
) (
   input  wire          clk_i,          // 200 MHz clock.
   input  wire          reset_i,        // Asynchronous reset, high.
   input  wire          group_mode_i,   // Parallel group mode enabled.
   input  wire          is_master_i,    // Unit configured as master.
   input  wire [4:0]    addr_cfg_i,     // Requested slave address.
   input  wire [1:0]    masters_seen_i, // Master count on the bus (0..2+).
   input  wire          init_req_i,     // Pulse: initialise group.
   input  wire          ack_i,          // Pulse: operator acknowledges alarm.
   input  wire          own_off_i,      // Own input stage shut down.
   input  wire          cr_req_i,       // Request resistance regulation.
   input  wire          ri_mode_i,      // Internal resistance mode active.
   input  wire          fg_analog_i,    // Generator start from analog port.
   input  wire          fg_remote_i,    // Generator start from remote.
   input  wire [1:0]    fg_type_i,      // Remote type, 0 is arbitrary.
   input  wire          remote_i,       // Remote control attempt.
   input  wire          manual_i,       // Manual control attempt.
   input  wire [VW-1:0] set_i,          // Local set value.
   input  wire [VW-1:0] own_act_i,      // Local actual value.
   input  wire [VW-1:0] unit_cap_i,     // Nominal capacity of one unit.
   input  wire          rxd_i,          // RS485 receive, asynchronous.
   output wire          txd_o,          // RS485 transmit data.
   output wire          tx_oe_o,        // RS485 driver enable.
   output reg  [4:0]    addr_o,         // Effective bus address.
   output wire          addr_err_o,     // Slave address out of range.
   output reg  [4:0]    slaves_o,       // Answering slaves.
   output reg           inited_o,       // Group initialised.
   output reg           init_fail_o,    // Initialisation failed.
   output reg  [VW+4:0] sum_act_o,      // Group actual total.
   output reg  [VW+4:0] range_o,        // Group adjustable range.
   output reg  [VW-1:0] share_o,        // Set value per unit.
   output reg           set_clr_o,      // Pulse: clear old set values.
   output reg  [15:0]   alarm_o,        // Held slave alarms.
   output wire          cr_en_o,        // Resistance regulation allowed.
   output wire          fg_en_o,        // Function generator allowed.
   output wire          ctrl_en_o       // Manual/remote control accepted.
);
   localparam S_IDLE = 6'h01;
   localparam S_SEND = 6'h02;
   localparam S_WAIT = 6'h04;
   localparam S_NEXT = 6'h08;
   localparam S_DONE = 6'h10;
   localparam S_DIST = 6'h20;

   reg        rx_m_q;
   reg        rx_s_q;
   reg [5:0]  st_q;
   reg [4:0]  idx_q;
   reg [4:0]  cnt_q;
   reg [15:0] alive_q;
   reg [15:0] reen_q;
   reg [31:0] tmo_q;
   reg [7:0]  tx_byte_q;
   reg        tx_go_q;
   reg        pwr_q;
   reg        off_sent_q;
   reg        scan_q;
   reg [VW+4:0] acc_q;
   wire       tx_busy;
   wire       rx_vld;
   wire [7:0] rx_byte;
   wire       slave_ok;
   wire       is_slave;

   always @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         rx_m_q <= 1'b1;
         rx_s_q <= 1'b1;
      end else begin
         rx_m_q <= rxd_i;
         rx_s_q <= rx_m_q;
      end
   end

   puc_uart_tx #(.BIT_CYC(BIT_CYC)) u_tx (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .start_i (tx_go_q),
      .data_i  (tx_byte_q),
      .busy_o  (tx_busy),
      .txd_o   (txd_o)
   );

   puc_uart_rx #(.BIT_CYC(BIT_CYC)) u_rx (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .rxd_i   (rx_s_q),
      .valid_o (rx_vld),
      .data_o  (rx_byte)
   );

   assign tx_oe_o = tx_busy;
   assign is_slave = group_mode_i && !is_master_i;
   assign slave_ok = (addr_cfg_i >= 5'h01) && (addr_cfg_i <= 5'h10);
   assign addr_err_o = is_slave && !slave_ok;
   assign cr_en_o = !group_mode_i && cr_req_i;
   assign fg_en_o = !group_mode_i && !ri_mode_i && !fg_analog_i
                    && (!fg_remote_i || fg_type_i == 2'h0);
   assign ctrl_en_o = !(is_slave && inited_o)
                      && (manual_i || remote_i);

   // Address: master pinned to zero, slave to its configured value when 1..16, else held.
   always @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         addr_o <= `PUC_MASTER_ADDR;
      end else if (is_master_i) begin
         addr_o <= `PUC_MASTER_ADDR;
      end else if (slave_ok) begin
         addr_o <= addr_cfg_i;
      end
   end

   // Scan, totals and distribution sequencer.
   always @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         st_q        <= S_IDLE;
         idx_q       <= 5'h00;
         cnt_q       <= 5'h00;
         alive_q     <= 16'h0000;
         reen_q      <= 16'h0000;
         alarm_o     <= 16'h0000;
         tmo_q       <= 32'h0000_0000;
         tx_byte_q   <= 8'h00;
         tx_go_q     <= 1'b0;
         pwr_q       <= 1'b1;
         off_sent_q  <= 1'b0;
         scan_q      <= 1'b0;
         acc_q       <= {(VW+5){1'b0}};
         slaves_o    <= 5'h00;
         inited_o    <= 1'b0;
         init_fail_o <= 1'b0;
         sum_act_o   <= {(VW+5){1'b0}};
         range_o     <= {(VW+5){1'b0}};
         share_o     <= {VW{1'b0}};
         set_clr_o   <= 1'b0;
      end else begin
         tx_go_q   <= 1'b0;
         set_clr_o <= 1'b0;
         if (ack_i) begin
            reen_q  <= alarm_o;
            alarm_o <= 16'h0000;
         end
         if (!group_mode_i) begin
            inited_o <= 1'b0;
            pwr_q    <= 1'b1;
            st_q     <= S_IDLE;
         end else if (!is_master_i) begin
            inited_o <= init_req_i | inited_o;
         end else begin
            case (st_q)
            S_IDLE: begin
               if (!own_off_i) begin
                  off_sent_q <= 1'b0;
               end
               if (init_req_i || pwr_q) begin
                  pwr_q <= 1'b0;
                  if (masters_seen_i != 2'h1) begin
                     init_fail_o <= 1'b1;
                     inited_o    <= 1'b0;
                  end else begin
                     init_fail_o <= 1'b0;
                     idx_q   <= 5'h01;
                     cnt_q   <= 5'h00;
                     alive_q <= 16'h0000;
                     scan_q  <= 1'b1;
                     acc_q   <= {5'h00, own_act_i};
                     st_q    <= S_SEND;
                  end
               end else if (inited_o) begin
                  idx_q  <= 5'h01;
                  scan_q <= 1'b0;
                  acc_q  <= {5'h00, own_act_i};
                  st_q   <= S_SEND;
               end
            end
            S_SEND: begin
               if (!tx_busy && !tx_go_q) begin
                  if (own_off_i && !off_sent_q) begin
                     tx_byte_q <= `PUC_CMD_OFF;
                  end else if (reen_q[idx_q[3:0] - 4'h1]) begin
                     // Addressed, so only the acknowledged slave restarts.
                     tx_byte_q <= `PUC_CMD_ON | {3'b000, idx_q};
                  end else begin
                     tx_byte_q <= {3'b101, idx_q};
                  end
                  tx_go_q <= 1'b1;
                  tmo_q   <= 32'h0000_0000;
                  st_q    <= S_WAIT;
               end
            end
            S_WAIT: begin
               if (rx_vld) begin
                  if (scan_q || alive_q[idx_q[3:0] - 4'h1]) begin
                     alive_q[idx_q[3:0] - 4'h1] <= 1'b1;
                     acc_q <= acc_q + {5'h00, own_act_i};
                     cnt_q <= cnt_q + 5'h01;
                  end
                  if (rx_byte == `PUC_RESP_ALARM) begin
                     alarm_o[idx_q[3:0] - 4'h1] <= 1'b1;
                  end
                  reen_q[idx_q[3:0] - 4'h1] <= 1'b0;
                  st_q <= S_NEXT;
               end else if (tmo_q == TMO_CYC - 1) begin
                  st_q <= S_NEXT;
                  if (!scan_q && alive_q[idx_q[3:0] - 4'h1]) begin
                     pwr_q <= 1'b1;
                  end
               end else begin
                  tmo_q <= tmo_q + 32'h0000_0001;
               end
            end
            S_NEXT: begin
               if (idx_q == `PUC_MAX_SLAVES) begin
                  if (own_off_i) begin
                     off_sent_q <= 1'b1;
                  end
                  st_q <= scan_q ? S_DONE : S_DIST;
               end else begin
                  idx_q <= idx_q + 5'h01;
                  st_q  <= S_SEND;
               end
            end
            S_DONE: begin
               slaves_o  <= cnt_q;
               inited_o  <= 1'b1;
               set_clr_o <= 1'b1;
               range_o   <= unit_cap_i * ({{VW{1'b0}}, cnt_q}
                            + {{(VW+4){1'b0}}, 1'b1});
               sum_act_o <= acc_q;
               share_o   <= {VW{1'b0}};
               st_q      <= S_IDLE;
            end
            S_DIST: begin
               sum_act_o <= acc_q;
               share_o   <= set_i / ({{(VW-5){1'b0}}, slaves_o}
                            + {{(VW-1){1'b0}}, 1'b1});
               st_q      <= S_IDLE;
            end
            default: st_q <= S_IDLE;
            endcase
         end
      end
   end
endmodule

// ### hw/puc_map.vh
// Constants for the parallel unit coordinator.
`ifndef PUC_MAP_VH
`define PUC_MAP_VH
`define PUC_CLK_HZ        200000000
`define PUC_BAUD          115200
`define PUC_BIT_CYC       (`PUC_CLK_HZ / `PUC_BAUD)
`define PUC_MAX_SLAVES    16
`define PUC_MASTER_ADDR   5'h00
`define PUC_CMD_POLL      8'hA0
`define PUC_CMD_OFF       8'hC0
`define PUC_CMD_ON        8'hE0
`define PUC_CMD_SET       8'h80
`define PUC_RESP_OK       8'h55
`define PUC_RESP_ALARM    8'hAA
`define PUC_REPLY_TMO_US  500
`define PUC_REPLY_TMO_CYC (`PUC_REPLY_TMO_US * 200)
`endif

// ### hw/puc_uart_tx.v
// Serial transmitter for the coordination link, 8N1.
`timescale 1ns/1ps
`include "puc_map.vh"
module puc_uart_tx #(
   parameter BIT_CYC = `PUC_BIT_CYC
) (
   input  wire       clk_i,    // System clock.
   input  wire       reset_i,  // Asynchronous reset.
   input  wire       start_i,  // Pulse to send one byte.
   input  wire [7:0] data_i,   // Byte to send.
   output wire       busy_o,   // High while a byte is in flight.
   output reg        txd_o     // Serial line output.
);
   reg [15:0] cnt_q;
   reg [9:0]  sh_q;
   reg [3:0]  nbit_q;
   assign busy_o = (nbit_q != 4'h0);
   always @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         cnt_q  <= 16'h0000;
         sh_q   <= 10'h3FF;
         nbit_q <= 4'h0;
         txd_o  <= 1'b1;
      end else if (nbit_q == 4'h0) begin
         txd_o <= 1'b1;
         if (start_i) begin
            sh_q   <= {1'b1, data_i, 1'b0};
            nbit_q <= 4'hA;
            cnt_q  <= 16'h0000;
         end
      end else begin
         txd_o <= sh_q[0];
         if (cnt_q == BIT_CYC[15:0] - 16'h0001) begin
            cnt_q  <= 16'h0000;
            sh_q   <= {1'b1, sh_q[9:1]};
            nbit_q <= nbit_q - 4'h1;
         end else begin
            cnt_q <= cnt_q + 16'h0001;
         end
      end
   end
endmodule

// ### hw/puc_uart_rx.v
// Serial receiver for the coordination link, 8N1.
`timescale 1ns/1ps
`include "puc_map.vh"
module puc_uart_rx #(
   parameter BIT_CYC = `PUC_BIT_CYC
) (
   input  wire       clk_i,    // System clock.
   input  wire       reset_i,  // Asynchronous reset.
   input  wire       rxd_i,    // Synchronised serial input.
   output reg        valid_o,  // One-cycle pulse per byte.
   output reg  [7:0] data_o    // Received byte.
);
   reg [15:0] cnt_q;
   reg [8:0]  sh_q;
   reg [3:0]  nbit_q;
   always @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         cnt_q   <= 16'h0000;
         sh_q    <= 9'h000;
         nbit_q  <= 4'h0;
         valid_o <= 1'b0;
         data_o  <= 8'h00;
      end else begin
         valid_o <= 1'b0;
         if (nbit_q == 4'h0) begin
            if (!rxd_i) begin
               nbit_q <= 4'hA;
               cnt_q  <= BIT_CYC[16:1];
            end
         end else if (cnt_q == BIT_CYC[15:0] - 16'h0001) begin
            cnt_q  <= 16'h0000;
            sh_q   <= {rxd_i, sh_q[8:1]};
            nbit_q <= nbit_q - 4'h1;
            if (nbit_q == 4'h1) begin
               data_o  <= sh_q[8:1];
               valid_o <= rxd_i;
            end
         end else begin
            cnt_q <= cnt_q + 16'h0001;
         end
      end
   end
endmodule

// ### verification/puc_coordinator_sva.sv
// Port assertions for the parallel unit coordinator.
`timescale 1ns/1ps
module puc_coordinator_sva #(
   parameter VW = 24
) (
   input wire          clk_i,          // Clock.
   input wire          reset_i,        // Reset.
   input wire          group_mode_i,   // Group mode.
   input wire          is_master_i,    // Master role.
   input wire [4:0]    addr_cfg_i,     // Address asked for.
   input wire [1:0]    masters_seen_i, // Masters on bus.
   input wire          ack_i,          // Alarm acknowledge.
   input wire          ri_mode_i,      // Resistance mode.
   input wire          txd_o,          // Serial out.
   input wire          tx_oe_o,        // Driver enable.
   input wire [4:0]    addr_o,         // Address used.
   input wire          addr_err_o,     // Address error.
   input wire [4:0]    slaves_o,       // Slave count.
   input wire          inited_o,       // Initialised.
   input wire          init_fail_o,    // Init failed.
   input wire          set_clr_o,      // Set clear pulse.
   input wire [15:0]   alarm_o,        // Held alarms.
   input wire          cr_en_o,        // Resistance allowed.
   input wire          fg_en_o,        // Generator allowed.
   input wire          ctrl_en_o       // Control allowed.
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (reset_i);
   sequence s_role;
      is_master_i [*2];
   endsequence
   sequence s_clr;
      set_clr_o ##1 !set_clr_o;
   endsequence
   master_addr_a: assert property (s_role |-> addr_o == 5'h00)
      else $error("master address not zero");
   slave_addr_a: assert property (!is_master_i |-> addr_err_o ==
      (addr_cfg_i == 5'h00 || addr_cfg_i > 5'h10))
      else $error("slave address check wrong");
   slave_max_a: assert property (slaves_o <= 5'h10)
      else $error("slave count above sixteen");
   cr_block_a: assert property (group_mode_i |-> !cr_en_o)
      else $error("resistance allowed in group");
   fg_block_a: assert property ((group_mode_i || ri_mode_i) |-> !fg_en_o)
      else $error("generator allowed");
   slave_lock_a: assert property (inited_o && !is_master_i |-> !ctrl_en_o)
      else $error("initialised slave accepts control");
   clear_pulse_a: assert property (set_clr_o |-> s_clr ##0 inited_o)
      else $error("set clear pulse wrong");
   fail_cause_a: assert property ($rose(init_fail_o) |-> masters_seen_i != 2'h1)
      else $error("init failed with one master");
   alarm_hold_a: assert property (!ack_i |=>
      (alarm_o & $past(alarm_o)) == $past(alarm_o))
      else $error("alarm lost without acknowledge");
   tx_idle_a: assert property (!tx_oe_o |-> txd_o)
      else $error("line not idle high");
endmodule
bind puc_coordinator puc_coordinator_sva #(.VW(VW)) u_sva (
   .clk_i(clk_i), .reset_i(reset_i), .group_mode_i(group_mode_i),
   .is_master_i(is_master_i), .addr_cfg_i(addr_cfg_i),
   .masters_seen_i(masters_seen_i), .ack_i(ack_i), .ri_mode_i(ri_mode_i),
   .txd_o(txd_o), .tx_oe_o(tx_oe_o), .addr_o(addr_o),
   .addr_err_o(addr_err_o), .slaves_o(slaves_o), .inited_o(inited_o),
   .init_fail_o(init_fail_o), .set_clr_o(set_clr_o), .alarm_o(alarm_o),
   .cr_en_o(cr_en_o), .fg_en_o(fg_en_o), .ctrl_en_o(ctrl_en_o));

// ### verification/puc_slave_model.sv
// Behavioural model of the slave units on the coordination link.
`timescale 1ns/1ps
`include "puc_map.vh"
module puc_slave_model #(
   parameter BIT = `PUC_BIT_CYC
) (
   input  wire        clk_i,   // System clock.
   input  wire        txd_i,   // Master transmit line.
   input  wire [15:0] alive_i, // Bit n-1 set when slave n answers.
   input  wire [15:0] alarm_i, // Slaves with an alarm to report.
   output reg         rxd_o    // Reply line, biased high when idle.
);
   reg [7:0]  b;
   reg [15:0] told;
   reg [3:0]  a;
   integer    i;
   task send(input [7:0] v);
      reg [9:0] f;
      integer   k;
      f = {1'b1, v, 1'b0};
      for (k = 0; k < 10; k = k + 1) begin
         rxd_o <= f[k];
         // Half a stop bit only: the next poll may follow the reply at once.
         repeat (k == 9 ? BIT / 2 : BIT) @(posedge clk_i);
      end
   endtask
   initial begin
      rxd_o <= 1'b1;
      told = 16'h0000;
      forever begin
         @(negedge txd_i);
         repeat (BIT / 2) @(posedge clk_i);
         for (i = 0; i < 8; i = i + 1) begin
            repeat (BIT) @(posedge clk_i);
            b[i] = txd_i;
         end
         repeat (BIT) @(posedge clk_i);
         a = 4'(b[4:0] - 5'h01);
         // Each slave answers only its own distinct address.
         // Polls and addressed re-enable commands are both answered.
         if ((b[7:5] == 3'b101 || b[7:5] == 3'b111) && b[4:0] != 5'h00
             && b[4:0] <= 5'h10 && alive_i[a]) begin
            if (alarm_i[a] && !told[a]) begin
               told[a] = 1'b1;
               send(8'hAA);
            end else
               send(8'h55);
         end
      end
   end
endmodule

// ### verification/testbench.sv
// Self-checking bench for the parallel unit coordinator.
`timescale 1ns/1ps
module testbench;
   typedef struct packed {
      logic        f;
      logic [4:0]  n;
      logic [28:0] s;
      logic [28:0] r;
   } puc_exp_t;
   reg         clk_i = 1'b0, reset_i = 1'b1;
   reg         group_mode_i = 1'b1, is_master_i = 1'b1;
   reg  [4:0]  addr_cfg_i = 5'h01;
   reg  [1:0]  masters_seen_i = 2'h2, fg_type_i = 2'h0;
   reg         ack_i = 1'b0, cr_req_i = 1'b0, ri_mode_i = 1'b0;
   reg         init_req_i = 1'b0;
   reg         fg_analog_i = 1'b0, fg_remote_i = 1'b0;
   reg         remote_i = 1'b0, manual_i = 1'b0;
   reg  [23:0] set_i = 24'h0, own_act_i = 24'h0, unit_cap_i = 24'h0;
   reg  [15:0] alive = 16'h0, alarm = 16'h0;
   reg         was_i = 1'b0, was_f = 1'b0;
   wire        rxd_i, txd_o, tx_oe_o, addr_err_o, inited_o, init_fail_o;
   wire        set_clr_o, cr_en_o, fg_en_o, ctrl_en_o;
   wire [4:0]  addr_o, slaves_o;
   wire [28:0] sum_act_o, range_o;
   wire [23:0] share_o;
   wire [15:0] alarm_o;
   int         miscompares = 0, n_tests = 0;
   puc_exp_t   q[$];
   puc_exp_t   e;
   logic [4:0] n;
   always #2.5 clk_i = ~clk_i;
   puc_coordinator #(.VW(24), .TMO_CYC(400), .BIT_CYC(16)) dut (
      .clk_i(clk_i), .reset_i(reset_i), .group_mode_i(group_mode_i),
      .is_master_i(is_master_i), .addr_cfg_i(addr_cfg_i),
      .masters_seen_i(masters_seen_i), .init_req_i(init_req_i),
      .ack_i(ack_i),
      .own_off_i(1'b0), .cr_req_i(cr_req_i), .ri_mode_i(ri_mode_i),
      .fg_analog_i(fg_analog_i), .fg_remote_i(fg_remote_i),
      .fg_type_i(fg_type_i), .remote_i(remote_i), .manual_i(manual_i),
      .set_i(set_i), .own_act_i(own_act_i), .unit_cap_i(unit_cap_i),
      .rxd_i(rxd_i), .txd_o(txd_o), .tx_oe_o(tx_oe_o), .addr_o(addr_o),
      .addr_err_o(addr_err_o), .slaves_o(slaves_o), .inited_o(inited_o),
      .init_fail_o(init_fail_o), .sum_act_o(sum_act_o), .range_o(range_o),
      .share_o(share_o), .set_clr_o(set_clr_o), .alarm_o(alarm_o),
      .cr_en_o(cr_en_o), .fg_en_o(fg_en_o), .ctrl_en_o(ctrl_en_o));
   puc_slave_model #(.BIT(16)) model (.clk_i(clk_i), .txd_i(txd_o),
      .alive_i(alive),
      .alarm_i(alarm), .rxd_o(rxd_i));
   task automatic chk(input string nm, input logic [31:0] x, g);
      n_tests++;
      if (x !== g) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", nm, x, g);
      end
   endtask
   task results;
      if (miscompares == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task wait_q(input int lim);
      for (int k = 0; k < lim && q.size() != 0; k++) @(posedge clk_i);
      #1;
      chk("pending", 0, q.size());
   endtask
   task reset_unit;
      #1 reset_i = 1'b1;
      repeat (10) @(posedge clk_i);
      #1 reset_i = 1'b0;
   endtask
   // The result monitor pairs each rise of inited_o or init_fail_o while is_master_i is set with the oldest note.
   always @(negedge clk_i) begin
      if (!reset_i && is_master_i
          && ((inited_o && !was_i) || (init_fail_o && !was_f))) begin
         e = q.pop_front();
         chk("init_fail_o", e.f, init_fail_o);
         if (!e.f) begin
            chk("slaves_o", e.n, slaves_o);
            chk("sum_act_o", e.s, sum_act_o);
            chk("range_o", e.r, range_o);
            chk("set_clr_o", 1, set_clr_o);
            chk("share_o", 0, share_o);
         end
      end
      if (!reset_i) begin
         chk("cr_en_o", !group_mode_i && cr_req_i, cr_en_o);
         chk("fg_en_o", !group_mode_i && !ri_mode_i
             && !fg_analog_i && (!fg_remote_i || fg_type_i == 2'h0),
             fg_en_o);
         chk("ctrl_en_o", (manual_i || remote_i)
             && !(inited_o && group_mode_i && !is_master_i), ctrl_en_o);
      end
      was_i <= inited_o;
      was_f <= init_fail_o;
   end
   always @(posedge clk_i) begin
      #1;
      {cr_req_i, ri_mode_i, fg_analog_i, fg_remote_i, remote_i} <= 5'($urandom);
      manual_i <= 1'($urandom);
      fg_type_i <= 2'($urandom);
      set_i <= 24'($urandom);
   end
   initial begin
      #(5 * 20000);
      miscompares++;
      results();
   end
   initial begin
      void'($urandom(32'h6f19));
      alive = 16'($urandom) | 16'h8000;
      own_act_i = 24'($urandom);
      unit_cap_i = 24'($urandom);
      q.push_back('{1'b1, 5'h00, 29'h0, 29'h0});
      reset_unit();
      wait_q(1000);
      masters_seen_i = 2'h1;
      alarm = alive & (~alive + 16'h0001);
      n = 5'($countones(alive));
      q.push_back('{1'b0, n, (29'(n) + 29'h1) * 29'(own_act_i),
                   (29'(n) + 29'h1) * 29'(unit_cap_i)});
      reset_unit();
      wait_q(10000);
      chk("addr_o", 5'h00, addr_o);
      chk("alarm_o", alarm, alarm_o);
      #1 ack_i = 1'b1;
      @(posedge clk_i);
      #1 ack_i = 1'b0;
      repeat (2) @(posedge clk_i);
      chk("alarm_o", 16'h0000, alarm_o);
      is_master_i = 1'b0;
      reset_unit();
      for (int j = 0; j < 4; j++) begin
         addr_cfg_i = 5'(j == 3 ? 16 : j + (j > 1 ? 15 : 0));
         repeat (3) @(posedge clk_i);
         chk("addr_err_o", addr_cfg_i == 0 || addr_cfg_i > 16, addr_err_o);
         chk("addr_o", j == 3 ? 16 : j != 0, addr_o);
         #1;
      end
      init_req_i = 1'b1;
      @(posedge clk_i);
      #1 init_req_i = 1'b0;
      repeat (2) @(posedge clk_i);
      chk("inited_o", 1, inited_o);
      #1 {group_mode_i, is_master_i} = 2'b01;
      repeat (200) @(posedge clk_i);
      results();
   end
endmodule
